/* irq_agg_pkg.sv */
package irq_agg_pkg;
    // Channel indices of the peripheral status lines
    localparam int            NUM_CH        = 4;
    localparam int            CH_SRQ        = 0;
    localparam int            CH_AGG        = 1;
    localparam int            CH_REN        = 2;
    // Request level field of configuration register one
    localparam int            LEVEL_W       = 3;
    localparam logic [2:0]    LEVEL_MIN     = 3'h1;
    localparam logic [2:0]    LEVEL_RST     = 3'h1;
    // Vector width and default vector values
    localparam int            VEC_W         = 8;
    localparam logic [7:0]    NORMAL_VEC_RST = 8'h40;
    localparam logic [7:0]    FAULT_VEC_RST  = 8'h41;
    // Line reset level: inactive high
    localparam logic [3:0]    LINES_RST     = 4'hf;
endpackage

/* line_channel.sv */
`timescale 1ns/1ns
// One channel: line level, falling-edge transition flag, interrupt request
module line_channel (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_line,
    input  wire logic i_irq_enable,
    input  wire logic i_clear_transition,
    output logic      o_level,
    output logic      o_transition,
    output logic      o_irq
);
    logic prev_line;
    logic next_transition;
    wire  falling = prev_line & ~i_line;

    // Set wins over clear so an edge in the clearing cycle is kept
    assign next_transition = falling |
                             (o_transition & ~i_clear_transition);

    // Level bit, edge flag and request all registered
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_line    <= 1'b1;
            o_level      <= 1'b1;
            o_transition <= 1'b0;
            o_irq        <= 1'b0;
        end else begin
            prev_line    <= i_line;
            o_level      <= i_line;
            o_transition <= next_transition;
            o_irq        <= next_transition & i_irq_enable;
        end
    end

    a_edge_sets_flag : assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $fell(i_line) |=> o_transition)
        else $error("Falling edge did not set transition flag");
endmodule

/* board_interrupt_aggregator.sv */
`timescale 1ns/1ns
// Functional notes
// - Interrupt on three event kinds only
// - Request level selectable one through seven
// - Sources ORed onto channel one line
// - Line level readable as status bit
// - Falling edge sets transition flag
// - Channels zero to two may interrupt on edge; channel three line is tied high
// - Channel one requests only when enabled
// - DMA bus error pulls line low
// - Synchronization after DMA pulls line low
// - Status read releases controller interrupt hold
// - Config one write clears synchronization
// - Bus error line returns on release
// - Channel one error sets fault, transition
// - Channel zero error: own fault, ch1 transition
// - Acknowledge returns normal or fault vector
// - Reading status register clears only the controller hold
// - Channel zero line follows SRQ low
// - Channel two line follows REN low
module board_interrupt_aggregator (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // Event sources
    input  wire logic        i_tlc_irq,
    input  wire logic        i_dma_done,
    input  wire logic        i_all_accepted,
    input  wire logic        i_berr_n,
    input  wire logic        i_ch0_active,
    input  wire logic        i_ch1_active,
    input  wire logic        i_srq_n,
    input  wire logic        i_ren_n,
    // Software accesses
    input  wire logic        i_irq_status_one_rd,
    input  wire logic        i_irq_status_two_rd,
    input  wire logic        i_config_reg_one_wr,
    input  wire logic [2:0]  i_config_level,
    input  wire logic [3:0]  i_channel_irq_enable,
    input  wire logic [3:0]  i_clear_transition,
    input  wire logic [1:0]  i_clear_fault,
    input  wire logic [7:0]  i_normal_vector,
    input  wire logic [7:0]  i_fault_vector,
    input  wire logic        i_normal_vector_wr,
    input  wire logic        i_fault_vector_wr,
    input  wire logic        i_iack,
    // Status and request outputs
    output logic [3:0]       o_line_level_bit,
    output logic [3:0]       o_line_transition_flag,
    output logic [1:0]       o_fault_flag,
    output logic             o_channel1_peripheral_line,
    output logic             o_sync_pending,
    output logic             o_tlc_hold,
    output logic             o_irq_req,
    output logic [2:0]       o_irq_level,
    output logic [7:0]       o_vector
);
    logic [3:0] lines;
    logic [3:0] chan_irq;
    logic [7:0] normal_vec;
    logic [7:0] fault_vec;
    logic       berr_prev;
    logic       next_sync;
    logic       next_tlc_hold;
    logic       next_line1;
    logic       next_irq;

    // A bus error is counted once per assertion of the error strobe
    wire berr_now   = ~i_berr_n;
    wire berr_start = berr_now & berr_prev;
    wire status_rd  = i_irq_status_one_rd | i_irq_status_two_rd;
    wire sync_event = i_dma_done & i_all_accepted;
    wire ch1_fault  = berr_start & i_ch1_active;
    wire ch0_fault  = berr_start & i_ch0_active & ~i_ch1_active;
    wire level_ok   = i_config_level >= irq_agg_pkg::LEVEL_MIN;

    // Sync condition: set wins over the clearing write
    assign next_sync = sync_event |
                       (o_sync_pending & ~i_config_reg_one_wr);
    // Controller interrupt latched until a status register read
    assign next_tlc_hold = (i_tlc_irq & ~status_rd) |
                           (o_tlc_hold & ~status_rd);
    // Any source low pulls the line; bus error releases on its own
    assign next_line1 = ~(next_tlc_hold | next_sync |
                          berr_now);
    assign next_irq = |chan_irq;

    // Line vector handed to the four channels
    assign lines = {1'b1, i_ren_n, next_line1, i_srq_n};

    // Per-channel edge detection and interrupt gating
    genvar ch;
    generate
        for (ch = 0; ch < irq_agg_pkg::NUM_CH; ch++) begin : g_ch
            line_channel u_ch (
                .i_mclk             (i_mclk),
                .i_rst_n            (i_rst_n),
                .i_line             (lines[ch]),
                .i_irq_enable       (i_channel_irq_enable[ch]),
                .i_clear_transition (i_clear_transition[ch]),
                .o_level            (o_line_level_bit[ch]),
                .o_transition       (o_line_transition_flag[ch]),
                .o_irq              (chan_irq[ch])
            );
        end
    endgenerate

    // Source latches and the aggregated line
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sync_pending             <= 1'b0;
            o_tlc_hold                 <= 1'b0;
            o_channel1_peripheral_line <= 1'b1;
            // Idle level is no error, so no false start follows reset
            berr_prev                  <= 1'b1;
        end else begin
            o_sync_pending             <= next_sync;
            o_tlc_hold                 <= next_tlc_hold;
            o_channel1_peripheral_line <= next_line1;
            berr_prev                  <= ~berr_now;
        end
    end

    // Fault flags per channel, set wins over clear
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fault_flag <= 2'h0;
        end else begin
            o_fault_flag[1] <= ch1_fault |
                               (o_fault_flag[1] & ~i_clear_fault[1]);
            o_fault_flag[0] <= ch0_fault |
                               (o_fault_flag[0] & ~i_clear_fault[0]);
        end
    end

    // Level register: out-of-range writes are ignored
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_level <= irq_agg_pkg::LEVEL_RST;
        end else if (i_config_reg_one_wr && level_ok) begin
            o_irq_level <= i_config_level;
        end
    end

    // Vector registers and request output
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            normal_vec <= irq_agg_pkg::NORMAL_VEC_RST;
            fault_vec  <= irq_agg_pkg::FAULT_VEC_RST;
            o_vector   <= irq_agg_pkg::NORMAL_VEC_RST;
            o_irq_req  <= 1'b0;
        end else begin
            if (i_normal_vector_wr) begin
                normal_vec <= i_normal_vector;
            end
            if (i_fault_vector_wr) begin
                fault_vec <= i_fault_vector;
            end
            // Vector picked on the channel one fault flag so the handler can branch
            o_vector  <= o_fault_flag[1] ? fault_vec : normal_vec;
            o_irq_req <= next_irq & ~i_iack;
        end
    end

    a_sync_pulls_low : assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_dma_done && i_all_accepted) |=> !o_channel1_peripheral_line)
        else $error("Sync did not pull line low");
    a_read_clears_hold : assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_irq_status_one_rd || i_irq_status_two_rd) |=> !o_tlc_hold)
        else $error("Status read did not clear hold");
    a_cfg_write_clears : assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_config_reg_one_wr && !(i_dma_done && i_all_accepted))
        |=> !o_sync_pending)
        else $error("Config write did not clear sync");
    a_berr_pulls_low : assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_berr_n |=> !o_channel1_peripheral_line)
        else $error("Bus error did not pull line low");
    a_line_returns_high : assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_berr_n && !o_sync_pending && !o_tlc_hold && !i_tlc_irq
         && !(i_dma_done && i_all_accepted))
        |=> o_channel1_peripheral_line)
        else $error("Line did not return high");
    a_ch1_fault_set : assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        ($fell(i_berr_n) && i_ch1_active) |=> o_fault_flag[1])
        else $error("Channel one fault not set");
    a_ch0_fault_only : assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        ($fell(i_berr_n) && i_ch0_active && !i_ch1_active)
        |=> o_fault_flag[0] && $stable(o_fault_flag[1]))
        else $error("Channel zero fault misrouted");
    a_vector_select : assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (o_fault_flag[1] && !i_fault_vector_wr && $stable(fault_vec))
        |=> o_vector == fault_vec)
        else $error("Wrong vector while fault set");
    a_level_in_range : assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        o_irq_level != 3'h0)
        else $error("Request level out of range");
endmodule

/* irq_handler_model.sv */
`timescale 1ns/1ns
// Handler CPU: acknowledges a pending request and keeps the vector it got
module irq_handler_model (
    input  wire logic       i_mclk,
    input  wire logic       i_irq_req,
    input  wire logic [7:0] i_vector,
    input  wire logic       i_serve,
    output logic            o_iack,
    output logic [7:0]      o_vec_seen
);
    initial o_iack = 1'b0;
    initial o_vec_seen = 8'h00;
    // One-cycle acknowledge, so a still-set flag is seen to request again
    always @(posedge i_mclk) begin
        o_iack <= i_serve & i_irq_req & ~o_iack;
        if (o_iack) begin
            o_vec_seen <= i_vector;
        end
    end
endmodule

/* board_interrupt_aggregator_tb.sv */
`timescale 1ns/1ns
module board_interrupt_aggregator_tb;
    typedef struct packed {
        logic talker_listener_controller, sync, berr_n, a0, a1, srq_n, ren_n, held;
        logic [3:0] lev, flag;
        logic [1:0] fault;
    } row_s;
    // Level and flag columns are ordered ch3..ch0
    localparam row_s ROWS [7] = '{
        '{1,0,1,0,0,1,1,1, 4'hd, 4'h2, 2'h0}, '{0,1,1,0,0,1,1,0, 4'hd, 4'h2, 2'h0},
        '{0,0,0,0,1,1,1,1, 4'hd, 4'h2, 2'h2}, '{0,0,0,1,0,1,1,1, 4'hd, 4'h2, 2'h1},
        '{0,0,0,1,1,1,1,1, 4'hd, 4'h2, 2'h2}, '{0,0,1,0,0,0,1,1, 4'he, 4'h1, 2'h0},
        '{0,0,1,0,0,1,0,1, 4'hb, 4'h4, 2'h0}};
    logic       i_mclk = 0, i_rst_n = 0, talker_listener_controller = 0, sync = 0, berr_n = 1;
    logic       act0 = 0, act1 = 0, srq_n = 1, ren_n = 1, rd1 = 0, rd2 = 0;
    logic       cfg_wr = 0, nv_wr = 0, fv_wr = 0, serve = 0;
    logic [2:0] lvl = 3'h1;
    logic [3:0] en = 4'hf, clr_t = 4'h0, lev, flag;
    logic [1:0] clr_f = 2'h0, fault;
    logic [7:0] nv = 8'h5a, fv = 8'ha5, vec, vseen;
    logic       line, syncp, hold, irq, iack;
    logic [2:0] irql;
    int         num_errors = 0, checks = 0;
    always #25 i_mclk = ~i_mclk;
    board_interrupt_aggregator i_board_interrupt_aggregator (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tlc_irq(talker_listener_controller), .i_dma_done(sync),
        .i_all_accepted(sync), .i_berr_n(berr_n), .i_ch0_active(act0),
        .i_ch1_active(act1), .i_srq_n(srq_n), .i_ren_n(ren_n),
        .i_irq_status_one_rd(rd1), .i_irq_status_two_rd(rd2),
        .i_config_reg_one_wr(cfg_wr), .i_config_level(lvl),
        .i_channel_irq_enable(en), .i_clear_transition(clr_t),
        .i_clear_fault(clr_f), .i_normal_vector(nv), .i_fault_vector(fv),
        .i_normal_vector_wr(nv_wr), .i_fault_vector_wr(fv_wr), .i_iack(iack),
        .o_line_level_bit(lev), .o_line_transition_flag(flag),
        .o_fault_flag(fault), .o_channel1_peripheral_line(line),
        .o_sync_pending(syncp), .o_tlc_hold(hold), .o_irq_req(irq),
        .o_irq_level(irql), .o_vector(vec));
    irq_handler_model i_irq_handler_model (.i_mclk(i_mclk), .i_irq_req(irq),
        .i_vector(vec), .i_serve(serve), .o_iack(iack), .o_vec_seen(vseen));
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cfg_write(input logic [2:0] v);
        @(posedge i_mclk) lvl <= v; cfg_wr <= 1;
        @(posedge i_mclk) cfg_wr <= 0;
    endtask
    // Drop every source, then read status two before one
    task automatic release_all();
        @(posedge i_mclk) {talker_listener_controller, sync, act0, act1} <= 0; berr_n <= 1;
        srq_n <= 1; ren_n <= 1; rd2 <= 1;
        @(posedge i_mclk) rd2 <= 0; rd1 <= 1;
        @(posedge i_mclk) rd1 <= 0;
        cyc(2);
    endtask
    task automatic clear_flags();
        @(posedge i_mclk) clr_t <= 4'hf; clr_f <= 2'h3;
        @(posedge i_mclk) clr_t <= 0; clr_f <= 0;
        cyc(3);
    endtask
    task automatic stop_test();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog sized well past the roughly 170 cycles the tests need
    initial begin
        cyc(3000);
        num_errors++;
        stop_test();
    end
    initial begin
        cyc(2);
        @(negedge i_mclk);
        cmp("reset out", 8'h81, {line, irq, flag, irql[1:0]});
        cmp("reset src", 8'h00, 8'({syncp, hold}));
        cmp("reset vec", irq_agg_pkg::NORMAL_VEC_RST, vec);
        @(posedge i_mclk) i_rst_n <= 1;
        cfg_write(3'h7);
        cyc(2);
        @(negedge i_mclk) cmp("level", 8'h7, 8'(irql));
        cfg_write(3'h0);
        cyc(2);
        @(negedge i_mclk) cmp("level", 8'h7, 8'(irql));
        foreach (ROWS[k]) begin
            @(posedge i_mclk) talker_listener_controller <= ROWS[k].talker_listener_controller;
            sync <= ROWS[k].sync;
            berr_n <= ROWS[k].berr_n;
            act0 <= ROWS[k].a0;
            act1 <= ROWS[k].a1;
            srq_n <= ROWS[k].srq_n;
            ren_n <= ROWS[k].ren_n;
            cyc(4);
            @(negedge i_mclk) cmp("line", 8'(ROWS[k].lev[1]), 8'(line));
            cmp("level", 8'(ROWS[k].lev), 8'(lev));
            cmp("flag", 8'(ROWS[k].flag), 8'(flag));
            cmp("fault", 8'(ROWS[k].fault), 8'(fault));
            cmp("src", 8'({ROWS[k].talker_listener_controller, ROWS[k].sync}), 8'({hold, syncp}));
            cmp("irq", 8'h1, 8'(irq));
            release_all();
            @(negedge i_mclk) cmp("held", 8'(ROWS[k].held), 8'(line));
            cfg_write(3'h7);
            clear_flags();
            @(negedge i_mclk) cmp("rest", 8'h1, {flag, fault, line});
        end
        @(posedge i_mclk) en <= 4'hd; talker_listener_controller <= 1;
        cyc(4);
        @(negedge i_mclk) cmp("masked", 8'h2, {irq, flag});
        release_all();
        clear_flags();
        @(posedge i_mclk) en <= 4'hf; nv_wr <= 1; fv_wr <= 1; serve <= 1;
        @(posedge i_mclk) nv_wr <= 0; fv_wr <= 0; act1 <= 1; berr_n <= 0;
        cyc(6);
        @(negedge i_mclk) cmp("fault vec", 8'ha5, vseen);
        release_all();
        clear_flags();
        @(posedge i_mclk) talker_listener_controller <= 1;
        cyc(6);
        @(negedge i_mclk) cmp("normal vec", 8'h5a, vseen);
        stop_test();
    end
endmodule
